//--- spimsk_core.sv
// APB register block of an SPI master: control, select mask, packet-end word, status
//
// Contract
// R01: Control register reads never alter any control bit.
// R02: Interrupt asserts when any status flag and its enable are both set.
// R03: Control bit 3 enables the receive-overrun interrupt.
// R04: Control bit 4 enables the transmit-overrun interrupt.
// R05: Control bits 6 and 7 enable transmitter-ready and receiver-ready interrupts.
// R06: Control bit 8 enables the interrupt for any error condition.
// R07: Control bit 9 enables the end-of-packet interrupt.
// R08: Control bit 10 keeps masked selects asserted even without a shift.
// R09: The select mask decides which selects assert whenever they are driven.
// R10: Reset clears every control bit.
// R11: During a shift only the masked selects assert.
// R12: The select mask exists only in a master build.
// R13: Select mask has one bit per select output, count is a parameter.
// R14: Several mask bits set assert all their selects together.
// R15: System must keep several selected slaves from fighting on their data outputs.
// R16: Reset sets mask bit 0 and clears the rest.
// R17: A writable register holds the packet-end word.
// R18: Error flag equals receive overrun OR transmit overrun.
// R19: Any status write clears both overrun flags and the error flag; an rx_load overrun in the same cycle still sets the receive overrun flag.
// R20: Packet-end flag sets when rx read or tx write data match the word.
// R21: Interrupt is a level, held while any enabled flag stays set.
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "spimsk_defines.svh"
module spimsk_core #(
  parameter int DATA_W    = 32,
  parameter int NUM_SS    = 4,
  parameter int ADDR_W    = 8,
  parameter bit IS_MASTER = 1'b1
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_load,
  input  wire logic [DATA_W-1:0] rx_word,
  input  wire logic              tx_take,
  input  wire logic              shift_busy,
  output logic      [DATA_W-1:0] tx_word,
  output logic                   tx_word_valid,
  output spimsk_pkg::spimsk_ctrl_t ctrl_out,
  output logic      [NUM_SS-1:0] ss_n,
  output logic                   irq
);
  import spimsk_pkg::*;

  // =====================================================================
  // State
  typedef struct packed {
    spimsk_ctrl_t      ctrl;
    logic [NUM_SS-1:0] ss_mask;
    logic [DATA_W-1:0] eop_word;
    logic [DATA_W-1:0] rx_data;
    logic [DATA_W-1:0] tx_data;
    logic              rx_ready_flag;
    logic              tx_ready_flag;
    logic              rx_overrun_flag;
    logic              tx_overrun_flag;
    logic              packet_end_flag;
    logic [31:0]       prdata;
  } spimsk_core_state_t;

  spimsk_core_state_t st_reg;
  spimsk_core_state_t st_next;

  // =====================================================================
  // Helpers
  function automatic logic [31:0] widen_data(input logic [DATA_W-1:0] v);
    logic [31:0] w;
    w            = '0;
    w[DATA_W-1:0] = v;
    return w;
  endfunction

  function automatic logic [31:0] widen_mask(input logic [NUM_SS-1:0] v);
    logic [31:0] w;
    w            = '0;
    w[NUM_SS-1:0] = v;
    return w;
  endfunction

  function automatic logic eop_match(input logic [DATA_W-1:0] v,
                                     input logic [DATA_W-1:0] e);
    return v == e;
  endfunction

  function automatic spimsk_reg_sel_t decode_sel(input logic [ADDR_W-1:0] a);
    spimsk_reg_sel_t s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0 && (a >> 5) == '0) begin
      case (a[4:2])
        `SPIMSK_IDX_RXDATA:  s = SEL_RXDATA;
        `SPIMSK_IDX_TXDATA:  s = SEL_TXDATA;
        `SPIMSK_IDX_STATUS:  s = SEL_STATUS;
        `SPIMSK_IDX_CTRL:    s = SEL_CTRL;
        `SPIMSK_IDX_SSMASK:  s = IS_MASTER ? SEL_SSMASK : SEL_NONE;  // R12
        `SPIMSK_IDX_EOPWORD: s = SEL_EOPWORD;
        default:             s = SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // =====================================================================
  // Bus decode
  spimsk_reg_sel_t sel;
  logic            setup_ph;
  logic            access_ph;
  logic            wr_acc;
  logic            rd_acc;
  logic            rd_setup;
  logic            rx_rd;
  logic            tx_wr;
  logic            err_flag;
  logic [31:0]     status_word;
  logic [31:0]     rd_mux;

  assign sel       = decode_sel(paddr);
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_acc    = access_ph & pwrite & (sel != SEL_NONE);
  assign rd_acc    = access_ph & ~pwrite & (sel != SEL_NONE);
  assign rd_setup  = setup_ph & ~pwrite;
  assign rx_rd     = rd_acc & (sel == SEL_RXDATA);
  assign tx_wr     = wr_acc & (sel == SEL_TXDATA);
  assign err_flag  = st_reg.rx_overrun_flag | st_reg.tx_overrun_flag;  // R18

  always_comb begin
    status_word                      = '0;
    status_word[`SPIMSK_ST_ROE]      = st_reg.rx_overrun_flag;
    status_word[`SPIMSK_ST_TOE]      = st_reg.tx_overrun_flag;
    status_word[`SPIMSK_ST_TMT]      = ~shift_busy;
    status_word[`SPIMSK_ST_TX_READY_FLAG]     = st_reg.tx_ready_flag;
    status_word[`SPIMSK_ST_RX_READY_FLAG]     = st_reg.rx_ready_flag;
    status_word[`SPIMSK_ST_ERR]      = err_flag;  // R18
    status_word[`SPIMSK_ST_EOP]      = st_reg.packet_end_flag;
  end

  always_comb begin
    case (sel)
      SEL_RXDATA:  rd_mux = widen_data(st_reg.rx_data);
      SEL_TXDATA:  rd_mux = widen_data(st_reg.tx_data);
      SEL_STATUS:  rd_mux = status_word;
      SEL_CTRL:    rd_mux = {21'h00_0000, st_reg.ctrl};  // R01
      SEL_SSMASK:  rd_mux = widen_mask(st_reg.ss_mask);
      SEL_EOPWORD: rd_mux = widen_data(st_reg.eop_word);
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  // =====================================================================
  // Next state; hardware sets are applied last so they win over clears, except the tx_take set of tx_ready_flag, which a tx data write clears after it
  always_comb begin
    st_next = st_reg;
    if (rd_setup) begin
      st_next.prdata = rd_mux;
    end
    if (wr_acc) begin
      case (sel)
        SEL_STATUS: begin
          st_next.rx_overrun_flag = 1'b0;  // R19
          st_next.tx_overrun_flag = 1'b0;  // R19
          st_next.packet_end_flag = 1'b0;
        end
        SEL_CTRL: begin
          st_next.ctrl = spimsk_ctrl_t'(pwdata[`SPIMSK_CTRL_W-1:0] & `SPIMSK_CTRL_MASK);
        end
        SEL_SSMASK: begin
          st_next.ss_mask = pwdata[NUM_SS-1:0];  // R13
        end
        SEL_EOPWORD: begin
          st_next.eop_word = pwdata[DATA_W-1:0];  // R17
        end
        default: begin
        end
      endcase
    end
    if (rx_rd) begin
      st_next.rx_ready_flag = 1'b0;
    end
    if (tx_take) begin
      st_next.tx_ready_flag = 1'b1;
    end
    if (rx_rd && eop_match(st_reg.rx_data, st_reg.eop_word)) begin
      st_next.packet_end_flag = 1'b1;  // R20
    end
    if (tx_wr) begin
      if (eop_match(pwdata[DATA_W-1:0], st_reg.eop_word)) begin
        st_next.packet_end_flag = 1'b1;  // R20
      end
      if (st_reg.tx_ready_flag) begin
        st_next.tx_data       = pwdata[DATA_W-1:0];
        st_next.tx_ready_flag = 1'b0;
      end else begin
        st_next.tx_overrun_flag = 1'b1;
      end
    end
    if (rx_load) begin
      st_next.rx_data       = rx_word;
      st_next.rx_ready_flag = 1'b1;
      if (st_reg.rx_ready_flag && !rx_rd) begin
        st_next.rx_overrun_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg                 <= '0;
      st_reg.ctrl            <= spimsk_ctrl_t'(`SPIMSK_CTRL_RST);  // R10
      st_reg.ss_mask         <= IS_MASTER ? NUM_SS'(`SPIMSK_SSMASK_RST) : '0;  // R16
      st_reg.eop_word        <= DATA_W'(`SPIMSK_EOPWORD_RST);
      st_reg.tx_ready_flag   <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // =====================================================================
  // Outputs
  assign prdata        = st_reg.prdata;
  assign pready        = 1'b1;
  assign pslverr       = access_ph & (sel == SEL_NONE);
  assign tx_word       = st_reg.tx_data;
  assign tx_word_valid = ~st_reg.tx_ready_flag;
  assign ctrl_out      = st_reg.ctrl;

  spimsk_select #(
    .NUM_SS    (NUM_SS),
    .IS_MASTER (IS_MASTER)
  ) spimsk_select_inst (
    .pclk               (pclk),
    .presetn            (presetn),
    .force_select_drive (st_reg.ctrl.force_select_drive),  // R08
    .shift_busy         (shift_busy),
    .ss_mask            (st_reg.ss_mask),  // R09
    .ss_n               (ss_n)
  );

  spimsk_irq spimsk_irq_inst (
    .pclk            (pclk),
    .presetn         (presetn),
    .ctrl            (st_reg.ctrl),  // R02
    .rx_overrun_flag (st_reg.rx_overrun_flag),
    .tx_overrun_flag (st_reg.tx_overrun_flag),
    .tx_ready_flag   (st_reg.tx_ready_flag),
    .rx_ready_flag   (st_reg.rx_ready_flag),
    .packet_end_flag (st_reg.packet_end_flag),
    .irq             (irq)
  );

  // =====================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ctrl_rd_setup;
    setup_ph && !pwrite && sel == SEL_CTRL;
  endsequence

  sequence s_ctrl_rd_access;
    access_ph && !pwrite && sel == SEL_CTRL;
  endsequence

  sequence s_status_wr;
    access_ph && pwrite && sel == SEL_STATUS;
  endsequence

  sequence s_eop_tx_wr;
    tx_wr && pwdata[DATA_W-1:0] == st_reg.eop_word;
  endsequence

  property p_irq_from(logic cause);
    cause |=> irq;
  endproperty

  AST_CTRL_READ_KEEP: assert property (  // R01
    s_ctrl_rd_setup ##1 s_ctrl_rd_access |=> st_reg.ctrl == $past(st_reg.ctrl, 2))
    else $error("control read changed control bits");
  AST_CTRL_READBACK: assert property (  // R01
    s_ctrl_rd_setup |=> prdata[10:0] == $past(st_reg.ctrl) && prdata[31:11] == '0)
    else $error("control read data wrong");
  AST_ROE_IRQ: assert property (  // R03
    p_irq_from(st_reg.rx_overrun_flag && st_reg.ctrl.rx_overrun_irq_enable))
    else $error("receive overrun interrupt missing");
  AST_TOE_IRQ: assert property (  // R04
    p_irq_from(st_reg.tx_overrun_flag && st_reg.ctrl.tx_overrun_irq_enable))
    else $error("transmit overrun interrupt missing");
  AST_RDY_IRQ: assert property (  // R05
    p_irq_from((st_reg.tx_ready_flag && st_reg.ctrl.tx_ready_irq_enable)
            || (st_reg.rx_ready_flag && st_reg.ctrl.rx_ready_irq_enable)))
    else $error("ready interrupt missing");
  AST_ERR_IRQ: assert property (  // R06
    p_irq_from(err_flag && st_reg.ctrl.any_error_irq_enable))
    else $error("error interrupt missing");
  AST_EOP_IRQ: assert property (  // R07
    p_irq_from(st_reg.packet_end_flag && st_reg.ctrl.packet_end_irq_enable))
    else $error("packet end interrupt missing");
  AST_IRQ_LEVEL: assert property (  // R21
    !((st_reg.rx_overrun_flag && st_reg.ctrl.rx_overrun_irq_enable)
      || (st_reg.tx_overrun_flag && st_reg.ctrl.tx_overrun_irq_enable)
      || (st_reg.tx_ready_flag && st_reg.ctrl.tx_ready_irq_enable)
      || (st_reg.rx_ready_flag && st_reg.ctrl.rx_ready_irq_enable)
      || (err_flag && st_reg.ctrl.any_error_irq_enable)
      || (st_reg.packet_end_flag && st_reg.ctrl.packet_end_irq_enable)) |=> !irq)
    else $error("interrupt without enabled cause");
  AST_STATUS_CLEAR: assert property (  // R19
    s_status_wr ##0 !rx_load |=> !st_reg.rx_overrun_flag && !st_reg.tx_overrun_flag)
    else $error("status write did not clear overrun flags");
  AST_ERR_READ: assert property (  // R18
    (setup_ph && !pwrite && sel == SEL_STATUS)
      |=> prdata[`SPIMSK_ST_ERR] == ($past(st_reg.rx_overrun_flag)
                                    || $past(st_reg.tx_overrun_flag)))
    else $error("error bit is not the OR of overruns");
  AST_EOP_TX: assert property (  // R20
    s_eop_tx_wr |=> st_reg.packet_end_flag)
    else $error("packet end not flagged on transmit write");
  AST_EOP_RX: assert property (  // R20
    (rx_rd && st_reg.rx_data == st_reg.eop_word) |=> st_reg.packet_end_flag)
    else $error("packet end not flagged on receive read");
  AST_EOP_WORD: assert property (  // R17
    (wr_acc && sel == SEL_EOPWORD) |=> st_reg.eop_word == $past(pwdata[DATA_W-1:0]))
    else $error("packet end word not stored");
  AST_MASK_WRITE: assert property (  // R13
    (wr_acc && sel == SEL_SSMASK) |=> st_reg.ss_mask == $past(pwdata[NUM_SS-1:0]))
    else $error("select mask not stored");
  AST_RX_OVERRUN: assert property (
    (rx_load && st_reg.rx_ready_flag && !rx_rd) |=> st_reg.rx_overrun_flag)
    else $error("receive overrun not flagged");

endmodule

//--- spimsk_core_test.sv
// Self-checking testbench of the SPI select and interrupt register block
`timescale 1ns/1ps
module spimsk_core_test;
  import spimsk_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic         rx_load, tx_take, shift_busy, tx_word_valid, irq, run, slow;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd, tx_word, rx_word;
  logic [3:0]   ss_n;
  spimsk_ctrl_t ctrl_out;
  int           n_fail, check_count;

  spimsk_core spimsk_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_load(rx_load), .rx_word(rx_word),
    .tx_take(tx_take), .shift_busy(shift_busy), .tx_word(tx_word),
    .tx_word_valid(tx_word_valid), .ctrl_out(ctrl_out), .ss_n(ss_n), .irq(irq));
  spimsk_shift_model spimsk_shift_model_inst (.pclk(pclk), .presetn(presetn), .run(run),
    .slow(slow), .tx_word(tx_word), .tx_word_valid(tx_word_valid), .tx_take(tx_take),
    .rx_load(rx_load), .rx_word(rx_word), .shift_busy(shift_busy));

  // ==================================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic done;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer and read data are taken at the rising edge that sees pready high
    do begin
      @(posedge pclk);
      done = pready;
      rd   = prdata;
      err  = pslverr;
    end while (done !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic settle_chk(input string what, input logic [31:0] seen_sel, input logic [31:0] exp);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check(what, seen_sel == 32'h1 ? {31'h0, irq} : {28'h0, ss_n}, exp);
  endtask
  task automatic wait_rx();
    int k;
    for (k = 0; k < 40 && rx_load !== 1'b1; k++) @(negedge pclk);
    check("rx_load", {31'h0, rx_load}, 32'h1);
    @(posedge pclk);
  endtask

  // ==================================================================
  // Scenarios
  task automatic t_reset();
    check("ctrl_out", {21'h0, ctrl_out}, 32'h0);
    check("ss_n", {28'h0, ss_n}, 32'hF);
    rdchk("ctrl", 8'h0C, 32'h0);
    rdchk("mask", 8'h14, 32'h1);
    rdchk("eop", 8'h18, 32'h0);
  endtask
  task automatic t_regs();
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    rdchk("ctrl", 8'h0C, 32'h7D8);
    rdchk("ctrl again", 8'h0C, 32'h7D8);
    check("ctrl_out", {21'h0, ctrl_out}, 32'h7D8);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    check("unmapped err", {31'h0, err}, 32'h1);
    rdchk("unmapped", 8'h10, 32'h0);
    apb(1'b1, 8'h18, 32'h1234_5678);
    rdchk("eop", 8'h18, 32'h1234_5678);
  endtask
  task automatic t_tx_irq();
    int b;
    apb(1'b1, 8'h0C, 32'h40);
    settle_chk("irq tx ready", 32'h1, 32'h1);
    apb(1'b1, 8'h0C, 32'h0);
    settle_chk("irq off", 32'h1, 32'h0);
    apb(1'b1, 8'h18, 32'hA5);
    apb(1'b1, 8'h04, 32'hA5);
    apb(1'b1, 8'h04, 32'h11);
    rdchk("status", 8'h08, 32'h330);
    check("tx_word", tx_word, 32'hA5);
    check("tx_word_valid", {31'h0, tx_word_valid}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? 4 : (i == 1) ? 8 : 9;
      apb(1'b1, 8'h0C, 32'h1 << b);
      settle_chk("irq", 32'h1, 32'h1);
    end
    apb(1'b1, 8'h08, 32'h0);
    rdchk("status clr", 8'h08, 32'h020);
    apb(1'b1, 8'h0C, 32'h318);
    settle_chk("irq cleared", 32'h1, 32'h0);
    apb(1'b1, 8'h0C, 32'h0);
  endtask
  task automatic t_rx();
    run <= 1'b1;
    wait_rx();
    apb(1'b1, 8'h04, 32'h2222);
    wait_rx();
    rdchk("status", 8'h08, 32'h1E8);
    apb(1'b1, 8'h0C, 32'h8);
    settle_chk("irq rx overrun", 32'h1, 32'h1);
    apb(1'b1, 8'h0C, 32'h80);
    settle_chk("irq rx ready", 32'h1, 32'h1);
    apb(1'b1, 8'h0C, 32'h0);
    apb(1'b1, 8'h18, 32'hFFFF_DDDD);
    rdchk("rxdata", 8'h00, 32'hFFFF_DDDD);
    rdchk("status eop", 8'h08, 32'h368);
    apb(1'b1, 8'h08, 32'h5);
    rdchk("status clr", 8'h08, 32'h060);
  endtask
  task automatic t_select();
    int k;
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    rdchk("mask", 8'h14, 32'hF);
    apb(1'b1, 8'h14, 32'hA);
    settle_chk("ss idle", 32'h0, 32'hF);
    apb(1'b1, 8'h0C, 32'h400);
    settle_chk("ss forced", 32'h0, 32'h5);
    apb(1'b1, 8'h0C, 32'h0);
    settle_chk("ss release", 32'h0, 32'hF);
    slow <= 1'b1;
    apb(1'b1, 8'h04, 32'h3333);
    for (k = 0; k < 20 && shift_busy !== 1'b1; k++) @(negedge pclk);
    settle_chk("ss shift", 32'h0, 32'h5);
    wait_rx();
    settle_chk("ss done", 32'h0, 32'hF);
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==================================================================
  // Clock, watchdog, main sequence
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (4000) @(posedge pclk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    {presetn, psel, penable, pwrite, run, slow} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    n_fail = 0;
    check_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    t_reset();
    t_regs();
    t_tx_irq();
    t_rx();
    t_select();
    report_and_stop();
  end
endmodule

//--- spimsk_defines.svh
// Register indices, field positions, reset values for the SPI select/interrupt block
`ifndef SPIMSK_DEFINES_SVH
`define SPIMSK_DEFINES_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define SPIMSK_IDX_RXDATA   3'h0
`define SPIMSK_IDX_TXDATA   3'h1
`define SPIMSK_IDX_STATUS   3'h2
`define SPIMSK_IDX_CTRL     3'h3
`define SPIMSK_IDX_SSMASK   3'h5
`define SPIMSK_IDX_EOPWORD  3'h6

// =====================================================================
// Status bit positions
`define SPIMSK_ST_ROE       3
`define SPIMSK_ST_TOE       4
`define SPIMSK_ST_TMT       5
`define SPIMSK_ST_TX_READY_FLAG      6
`define SPIMSK_ST_RX_READY_FLAG      7
`define SPIMSK_ST_ERR       8
`define SPIMSK_ST_EOP       9

// =====================================================================
// Control layout and reset values
`define SPIMSK_CTRL_W       11
`define SPIMSK_CTRL_MASK    11'h7D8
`define SPIMSK_CTRL_RST     11'h000
`define SPIMSK_SSMASK_RST   32'h0000_0001
`define SPIMSK_EOPWORD_RST  32'h0000_0000

`endif

//--- spimsk_irq.sv
// Interrupt request combiner: enabled status conditions onto one level output
`timescale 1ns/1ps
module spimsk_irq (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  spimsk_pkg::spimsk_ctrl_t  ctrl,
  input  wire logic                 rx_overrun_flag,
  input  wire logic                 tx_overrun_flag,
  input  wire logic                 tx_ready_flag,
  input  wire logic                 rx_ready_flag,
  input  wire logic                 packet_end_flag,
  output logic                      irq
);
  import spimsk_pkg::*;

  typedef struct packed {
    logic irq;
  } spimsk_irq_state_t;

  spimsk_irq_state_t st_reg;
  spimsk_irq_state_t st_next;
  logic              any_err;

  assign any_err = rx_overrun_flag | tx_overrun_flag;  // R18

  always_comb begin
    st_next     = st_reg;
    st_next.irq = (rx_overrun_flag & ctrl.rx_overrun_irq_enable)  // R03
                | (tx_overrun_flag & ctrl.tx_overrun_irq_enable)  // R04
                | (tx_ready_flag & ctrl.tx_ready_irq_enable)      // R05
                | (rx_ready_flag & ctrl.rx_ready_irq_enable)      // R05
                | (any_err & ctrl.any_error_irq_enable)           // R06
                | (packet_end_flag & ctrl.packet_end_irq_enable); // R07
  end

  // Level output, follows the conditions one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;  // R02 R21
    end
  end

  assign irq = st_reg.irq;

endmodule

//--- spimsk_pkg.sv
// Types shared by the SPI select/interrupt block
package spimsk_pkg;

  // =====================================================================
  // Control register fields, bit 10 down to bit 0
  typedef struct packed {
    logic       force_select_drive;
    logic       packet_end_irq_enable;
    logic       any_error_irq_enable;
    logic       rx_ready_irq_enable;
    logic       tx_ready_irq_enable;
    logic       rsvd5;
    logic       tx_overrun_irq_enable;
    logic       rx_overrun_irq_enable;
    logic [2:0] rsvd2_0;
  } spimsk_ctrl_t;

  typedef enum {
    SEL_NONE, SEL_RXDATA, SEL_TXDATA, SEL_STATUS, SEL_CTRL, SEL_SSMASK, SEL_EOPWORD
  } spimsk_reg_sel_t;

endpackage

//--- spimsk_select.sv
// Slave-select driver: masks the active-low select lines
`timescale 1ns/1ps
module spimsk_select #(
  parameter int NUM_SS    = 4,
  parameter bit IS_MASTER = 1'b1
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              force_select_drive,
  input  wire logic              shift_busy,
  input  wire logic [NUM_SS-1:0] ss_mask,
  output logic      [NUM_SS-1:0] ss_n
);
  typedef struct packed {
    logic [NUM_SS-1:0] ss_n;
  } spimsk_sel_state_t;

  spimsk_sel_state_t st_reg;
  spimsk_sel_state_t st_next;
  logic              drive;

  assign drive = IS_MASTER && (force_select_drive || shift_busy);  // R08 R12

  always_comb begin
    st_next      = st_reg;
    st_next.ss_n = drive ? ~ss_mask : '1;  // R09 R11 R14
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{ss_n: '1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ss_n = st_reg.ss_n;

  // =====================================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SEL_FORCE: assert property (  // R08
    (IS_MASTER && force_select_drive) |=> ss_n == ~$past(ss_mask))
    else $error("forced select does not follow the mask");
  AST_SEL_SHIFT: assert property (  // R11
    (IS_MASTER && shift_busy && !force_select_drive) |=> ss_n == ~$past(ss_mask))
    else $error("select during shift does not follow the mask");
  AST_SEL_IDLE: assert property (  // R11
    (!shift_busy && !force_select_drive) |=> ss_n == '1)
    else $error("select asserted while idle");
  AST_SEL_SLAVE: assert property (  // R12
    !IS_MASTER |-> ss_n == '1)
    else $error("slave build drives a select line");

endmodule

//--- spimsk_shift_model.sv
// Behavioural shift engine and far-side slave that takes a word and returns its inverse
`timescale 1ns/1ps
module spimsk_shift_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic        slow,
  input  wire logic [31:0] tx_word,
  input  wire logic        tx_word_valid,
  output logic             tx_take,
  output logic             rx_load,
  output logic      [31:0] rx_word,
  output logic             shift_busy
);
  logic [3:0]  cnt_reg;
  logic [31:0] hold_reg;
  // ==================================================================
  // Shift lasts 2 cycles when prompt, 8 when slow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_take    <= 1'b0;
      rx_load    <= 1'b0;
      rx_word    <= 32'h5A5A_5A5A;
      shift_busy <= 1'b0;
      cnt_reg    <= 4'h0;
      hold_reg   <= 32'h0;
    end else begin
      tx_take <= 1'b0;
      rx_load <= 1'b0;
      // Only one slave replies; the data line toggles outside a load
      rx_word <= ~rx_word;
      if (shift_busy) begin
        cnt_reg <= cnt_reg - 4'h1;
        if (cnt_reg == 4'h0) begin
          shift_busy <= 1'b0;
          rx_load    <= 1'b1;
          rx_word    <= ~hold_reg;
        end
      end else if (run && tx_word_valid && !tx_take) begin
        tx_take    <= 1'b1;
        shift_busy <= 1'b1;
        hold_reg   <= tx_word;
        cnt_reg    <= slow ? 4'h7 : 4'h1;
      end
    end
  end
endmodule
